// ===== hw/tfrc_timer.sv
// What this block does
// RQ1: A 16-bit up-counter, read by software as high and low byte.
// RQ2: An alternate byte pair reads the same count without touching the flag.
// RQ3: Writing either low byte loads the counter with FFFCh.
// RQ4: Reset starts the counter at FFFCh, the only value ever loaded.
// RQ5: Two select bits give ticks at clock over 2, 4, 8 or external.
// RQ6: The external pin drives the count only when both select bits are one.
// RQ7: An edge bit picks the active external edge, synchronised to the clock.
// RQ8: The external source spaces active edges at least nine clock edges apart.
// RQ9: Reading a high byte first stores the low byte for the later read.
// RQ10: The stored low byte holds until read, despite repeated high reads.
// RQ11: After a complete pair, a lone low read returns the live low byte.
// RQ12: The overflow flag sets when the count wraps from FFFFh to 0000h.
// RQ13: Overflow requests an interrupt if enabled and the CPU mask is clear.
// RQ14: Flag clears by status read while set, then counter low access.
// RQ15: Wait mode leaves counting untouched.
// RQ16: Halt freezes the count; interrupt wake resumes, reset wake restarts.
// RQ17: An external pin that is not bonded out reads as one.
// RQ18: The internal reset is active high and holds the timer.
// RQ19: Each enabled tick adds exactly one and wraps from maximum to zero.
`timescale 1ns/1ps
`default_nettype none

module tfrc_timer
    import tfrc_pkg::*;
#(
    parameter bit EXT_PIN_BONDED = 1'b1
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ext_tick_pin,
    input  wire logic        cpu_irq_mask,
    input  wire logic        wait_mode,
    input  wire logic        halt_mode,
    output var  logic        timer_irq_req,
    output var  logic        irq
);

    // ----------------------------------------------------------------
    // Internal reset and external tick
    // ----------------------------------------------------------------
    logic rst_int;
    logic ext_pin_seen;
    logic ext_tick;

    // RQ18: high holds reset
    assign rst_int = ~aresetn;

    // RQ17: unbonded reads one
    assign ext_pin_seen = EXT_PIN_BONDED ? ext_tick_pin : 1'b1;

    tfrc_ctl_s ctl_ff;
    tfrc_ctl_s nxt_ctl;

    tfrc_ext_sync u_ext_sync
    (
        .aclk        (aclk),
        .rst_int     (rst_int),
        .pin_in      (ext_pin_seen),
        .edge_rising (ctl_ff.ext_edge_select),
        .tick        (ext_tick)
    );

    // ----------------------------------------------------------------
    // Bus state
    // ----------------------------------------------------------------
    logic        aw_held_ff;
    logic        nxt_aw_held;
    logic [7:0]  aw_addr_ff;
    logic [7:0]  nxt_aw_addr;
    logic        w_held_ff;
    logic        nxt_w_held;
    logic [31:0] w_data_ff;
    logic [31:0] nxt_w_data;
    logic [3:0]  w_strb_ff;
    logic [3:0]  nxt_w_strb;
    logic        bvalid_ff;
    logic        nxt_bvalid;
    logic [1:0]  bresp_ff;
    logic [1:0]  nxt_bresp;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic [1:0]  rresp_ff;
    logic [1:0]  nxt_rresp;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    logic        wr_do;
    logic        rd_do;
    tfrc_reg_e   wr_reg;
    tfrc_reg_e   rd_reg;
    logic        wr_lane0;

    // ----------------------------------------------------------------
    // Timer state
    // ----------------------------------------------------------------
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [2:0]  presc_ff;
    logic [2:0]  nxt_presc;
    logic [7:0]  lo_buf_ff;
    logic [7:0]  nxt_lo_buf;
    logic        lo_held_ff;
    logic        nxt_lo_held;
    logic        ovf_flag_ff;
    logic        nxt_ovf_flag;
    logic        clr_armed_ff;
    logic        nxt_clr_armed;
    logic        irq_stat_ff;
    logic        nxt_irq_stat;
    logic        irq_mask_ff;
    logic        nxt_irq_mask;

    logic        tick;
    logic        int_tick;
    logic        wrap;
    logic        load;
    logic        lo_access;
    logic [2:0]  div_mask;

    // ----------------------------------------------------------------
    // Write and read channel handshakes
    // ----------------------------------------------------------------
    assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rdata_ff;

    assign wr_do    = aw_held_ff & w_held_ff & ~bvalid_ff;
    assign rd_do    = s_axi_arvalid & ~rvalid_ff;
    assign wr_reg   = tfrc_decode(aw_addr_ff);
    assign rd_reg   = tfrc_decode(s_axi_araddr);
    assign wr_lane0 = wr_do & w_strb_ff[0];

    always_comb
    begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held  = w_held_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_strb  = w_strb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        if (s_axi_awvalid && s_axi_awready)
        begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            nxt_w_held = 1'b1;
            nxt_w_data = s_axi_wdata;
            nxt_w_strb = s_axi_wstrb;
        end
        if (wr_do)
        begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = (wr_reg == TFRC_R_NONE) ? TFRC_RESP_SLVERR
                                                  : TFRC_RESP_OKAY;
        end
        else if (bvalid_ff && s_axi_bready)
        begin
            nxt_bvalid = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read data, taken the cycle the address is accepted
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_rvalid = rvalid_ff;
        nxt_rresp  = rresp_ff;
        nxt_rdata  = rdata_ff;
        if (rd_do)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = TFRC_RESP_OKAY;
            nxt_rdata  = 32'h0000_0000;
            unique case (rd_reg)
                // RQ1: high byte
                TFRC_R_CNT_HI, TFRC_R_ALT_HI:
                    nxt_rdata[7:0] = cnt_ff[15:8];
                // RQ11: buffered or live low
                TFRC_R_CNT_LO, TFRC_R_ALT_LO:
                    nxt_rdata[7:0] = lo_held_ff ? lo_buf_ff : cnt_ff[7:0];
                TFRC_R_STATUS:
                    nxt_rdata[TFRC_OVF_BIT] = ovf_flag_ff;
                TFRC_R_CTRL1:
                    nxt_rdata[TFRC_IRQEN_BIT] = ctl_ff.overflow_irq_enable;
                TFRC_R_CTRL2:
                begin
                    nxt_rdata[TFRC_SEL_LSB +: 2] = ctl_ff.tick_source_select;
                    nxt_rdata[TFRC_EDGE_BIT]     = ctl_ff.ext_edge_select;
                end
                TFRC_R_IRQ_STAT:
                    nxt_rdata[TFRC_OVF_BIT] = irq_stat_ff;
                TFRC_R_IRQ_MASK:
                    nxt_rdata[TFRC_OVF_BIT] = irq_mask_ff;
                TFRC_R_NONE:
                    nxt_rresp = TFRC_RESP_SLVERR;
            endcase
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (rst_int)
        begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_held_ff  <= 1'b0;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= TFRC_RESP_OKAY;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= TFRC_RESP_OKAY;
            rdata_ff   <= 32'h0000_0000;
        end
        else
        begin
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
            w_held_ff  <= nxt_w_held;
            w_data_ff  <= nxt_w_data;
            w_strb_ff  <= nxt_w_strb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            rvalid_ff  <= nxt_rvalid;
            rresp_ff   <= nxt_rresp;
            rdata_ff   <= nxt_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_ctl      = ctl_ff;
        nxt_irq_mask = irq_mask_ff;
        if (wr_lane0)
        begin
            unique case (wr_reg)
                TFRC_R_CTRL1:
                    nxt_ctl.overflow_irq_enable =
                        w_data_ff[TFRC_IRQEN_BIT];
                TFRC_R_CTRL2:
                begin
                    nxt_ctl.tick_source_select =
                        w_data_ff[TFRC_SEL_LSB +: 2];
                    nxt_ctl.ext_edge_select = w_data_ff[TFRC_EDGE_BIT];
                end
                TFRC_R_IRQ_MASK:
                    nxt_irq_mask = w_data_ff[TFRC_OVF_BIT];
                default:
                    nxt_ctl = ctl_ff;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Tick generation
    // ----------------------------------------------------------------
    // RQ5: prescaler divide
    always_comb
    begin
        unique case (ctl_ff.tick_source_select)
            2'h0:    div_mask = TFRC_DIV2_MASK;
            2'h1:    div_mask = TFRC_DIV4_MASK;
            2'h2:    div_mask = TFRC_DIV8_MASK;
            2'h3:    div_mask = TFRC_DIV8_MASK;
        endcase
    end

    // RQ15: wait not used
    // RQ16: halt freezes count
    assign int_tick = ((presc_ff & div_mask) == div_mask) & ~halt_mode;

    // RQ6: external only at 11
    assign tick = (ctl_ff.tick_source_select == TFRC_SEL_EXT)
                  ? (ext_tick & ~halt_mode) : int_tick;

    // RQ3: low byte write loads
    assign load = wr_lane0 &
                  ((wr_reg == TFRC_R_CNT_LO) || (wr_reg == TFRC_R_ALT_LO));

    // RQ12: wrap detect
    assign wrap = tick & ~load & (cnt_ff == TFRC_CNT_MAX);

    assign lo_access = (rd_do && rd_reg == TFRC_R_CNT_LO) ||
                       (wr_do && wr_reg == TFRC_R_CNT_LO);

    // ----------------------------------------------------------------
    // Counter, read buffer and flags
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_presc     = halt_mode ? presc_ff : presc_ff + 3'h1;
        nxt_cnt       = cnt_ff;
        nxt_lo_buf    = lo_buf_ff;
        nxt_lo_held   = lo_held_ff;
        nxt_ovf_flag  = ovf_flag_ff;
        nxt_clr_armed = clr_armed_ff;
        nxt_irq_stat  = irq_stat_ff;

        // RQ4: only FFFCh loaded
        if (load)
        begin
            nxt_cnt = TFRC_CNT_RESET;
        end
        // RQ19: plus one, wraps
        else if (tick)
        begin
            nxt_cnt = cnt_ff + 16'h0001;
        end

        // RQ9: high read stores low
        // RQ10: buffer kept on rereads
        if (rd_do && (rd_reg == TFRC_R_CNT_HI || rd_reg == TFRC_R_ALT_HI)
            && !lo_held_ff)
        begin
            nxt_lo_buf  = cnt_ff[7:0];
            nxt_lo_held = 1'b1;
        end
        else if (rd_do &&
                 (rd_reg == TFRC_R_CNT_LO || rd_reg == TFRC_R_ALT_LO))
        begin
            nxt_lo_held = 1'b0;
        end

        // RQ14: two-step clear
        // RQ2: alternate low exempt
        if (rd_do && rd_reg == TFRC_R_STATUS && ovf_flag_ff)
        begin
            nxt_clr_armed = 1'b1;
        end
        if (lo_access && clr_armed_ff)
        begin
            nxt_ovf_flag  = 1'b0;
            nxt_clr_armed = 1'b0;
        end

        if (rd_do && rd_reg == TFRC_R_IRQ_STAT)
        begin
            nxt_irq_stat = 1'b0;
        end

        // RQ12: set beats clear
        if (wrap)
        begin
            nxt_ovf_flag  = 1'b1;
            nxt_irq_stat  = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (rst_int)
        begin
            ctl_ff       <= '{ext_edge_select:     1'b0,
                              tick_source_select:  TFRC_SEL_RESET,
                              overflow_irq_enable: 1'b0};
            irq_mask_ff  <= 1'b0;
            presc_ff     <= 3'h0;
            cnt_ff       <= TFRC_CNT_RESET;
            lo_buf_ff    <= 8'h00;
            lo_held_ff   <= 1'b0;
            ovf_flag_ff  <= 1'b0;
            clr_armed_ff <= 1'b0;
            irq_stat_ff  <= 1'b0;
        end
        else
        begin
            ctl_ff       <= nxt_ctl;
            irq_mask_ff  <= nxt_irq_mask;
            presc_ff     <= nxt_presc;
            cnt_ff       <= nxt_cnt;
            lo_buf_ff    <= nxt_lo_buf;
            lo_held_ff   <= nxt_lo_held;
            ovf_flag_ff  <= nxt_ovf_flag;
            clr_armed_ff <= nxt_clr_armed;
            irq_stat_ff  <= nxt_irq_stat;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt outputs
    // ----------------------------------------------------------------
    // RQ13: pending until enabled
    assign timer_irq_req = ovf_flag_ff & ctl_ff.overflow_irq_enable &
                           ~cpu_irq_mask;
    assign irq           = irq_stat_ff & irq_mask_ff;

endmodule : tfrc_timer

`default_nettype wire

// ===== include/tfrc_pkg.sv
package tfrc_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] TFRC_CNT_HI_OFS   = 8'h00;
    localparam logic [7:0] TFRC_CNT_LO_OFS   = 8'h04;
    localparam logic [7:0] TFRC_ALT_HI_OFS   = 8'h08;
    localparam logic [7:0] TFRC_ALT_LO_OFS   = 8'h0C;
    localparam logic [7:0] TFRC_STATUS_OFS   = 8'h10;
    localparam logic [7:0] TFRC_CTRL1_OFS    = 8'h14;
    localparam logic [7:0] TFRC_CTRL2_OFS    = 8'h18;
    localparam logic [7:0] TFRC_IRQ_STAT_OFS = 8'h1C;
    localparam logic [7:0] TFRC_IRQ_MASK_OFS = 8'h20;

    // ----------------------------------------------------------------
    // Field positions, reset values and answers
    // ----------------------------------------------------------------
    localparam int         TFRC_OVF_BIT      = 0;
    localparam int         TFRC_IRQEN_BIT    = 0;
    localparam int         TFRC_SEL_LSB      = 0;
    localparam int         TFRC_EDGE_BIT     = 2;
    localparam logic [15:0] TFRC_CNT_RESET   = 16'hFFFC;
    localparam logic [15:0] TFRC_CNT_MAX     = 16'hFFFF;
    localparam logic [1:0] TFRC_SEL_RESET    = 2'h0;
    localparam logic [1:0] TFRC_SEL_EXT      = 2'h3;
    localparam logic [1:0] TFRC_RESP_OKAY    = 2'h0;
    localparam logic [1:0] TFRC_RESP_SLVERR  = 2'h2;
    localparam logic [2:0] TFRC_DIV2_MASK    = 3'h1;
    localparam logic [2:0] TFRC_DIV4_MASK    = 3'h3;
    localparam logic [2:0] TFRC_DIV8_MASK    = 3'h7;

    typedef enum logic [3:0] {
        TFRC_R_CNT_HI,
        TFRC_R_CNT_LO,
        TFRC_R_ALT_HI,
        TFRC_R_ALT_LO,
        TFRC_R_STATUS,
        TFRC_R_CTRL1,
        TFRC_R_CTRL2,
        TFRC_R_IRQ_STAT,
        TFRC_R_IRQ_MASK,
        TFRC_R_NONE
    } tfrc_reg_e;

    typedef struct packed {
        logic       ext_edge_select;
        logic [1:0] tick_source_select;
        logic       overflow_irq_enable;
    } tfrc_ctl_s;

    // Maps a byte address onto a register, shared by reads and writes.
    function automatic tfrc_reg_e tfrc_decode(input logic [7:0] addr);
        unique case (addr)
            TFRC_CNT_HI_OFS:   return TFRC_R_CNT_HI;
            TFRC_CNT_LO_OFS:   return TFRC_R_CNT_LO;
            TFRC_ALT_HI_OFS:   return TFRC_R_ALT_HI;
            TFRC_ALT_LO_OFS:   return TFRC_R_ALT_LO;
            TFRC_STATUS_OFS:   return TFRC_R_STATUS;
            TFRC_CTRL1_OFS:    return TFRC_R_CTRL1;
            TFRC_CTRL2_OFS:    return TFRC_R_CTRL2;
            TFRC_IRQ_STAT_OFS: return TFRC_R_IRQ_STAT;
            TFRC_IRQ_MASK_OFS: return TFRC_R_IRQ_MASK;
            default:           return TFRC_R_NONE;
        endcase
    endfunction : tfrc_decode

endpackage : tfrc_pkg

// ===== hw/tfrc_ext_sync.sv
`timescale 1ns/1ps
`default_nettype none

module tfrc_ext_sync
(
    input  wire logic aclk,
    input  wire logic rst_int,
    input  wire logic pin_in,
    input  wire logic edge_rising,
    output var  logic tick
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic lvl_ff;
    logic nxt_lvl;
    logic nxt_tick;
    logic tick_ff;

    // ----------------------------------------------------------------
    // Level filter and edge detect
    // ----------------------------------------------------------------
    // RQ7: chosen edge
    always_comb
    begin
        nxt_lvl  = lvl_ff;
        nxt_tick = 1'b0;
        if (s2_ff == s3_ff)
        begin
            nxt_lvl  = s3_ff;
            nxt_tick = (s3_ff != lvl_ff) && (s3_ff == edge_rising);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (rst_int)
        begin
            s1_ff   <= 1'b1;
            s2_ff   <= 1'b1;
            s3_ff   <= 1'b1;
            lvl_ff  <= 1'b1;
            tick_ff <= 1'b0;
        end
        else
        begin
            s1_ff   <= pin_in;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            lvl_ff  <= nxt_lvl;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule : tfrc_ext_sync

`default_nettype wire

// ===== tb/tfrc_ext_src.sv
`timescale 1ns/1ps
`default_nettype none

module tfrc_ext_src
(
    input  wire logic aclk,
    output var  logic ext_tick_pin
);
    initial ext_tick_pin = 1'b1;

    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge aclk);
            ext_tick_pin <= 1'b0;
            repeat (4) @(posedge aclk);
            ext_tick_pin <= 1'b1;
            repeat (4) @(posedge aclk);
        end
        repeat (8) @(posedge aclk);
    endtask : pulse
endmodule : tfrc_ext_src

`default_nettype wire

// ===== tb/tfrc_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none

module tfrc_timer_checker
    import tfrc_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        cpu_irq_mask,
    input wire logic        timer_irq_req
);
    // ------------------------------------------------------------
    // Bus and interrupt properties
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read lost");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("ar open");
    property p_byte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_byte: assert property (p_byte) else $error("upper bits set");
    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write lost");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp moved");
    property p_unmap;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h24
            |=> s_axi_rresp == TFRC_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped ok");
    property p_irq_mask; cpu_irq_mask |-> !timer_irq_req; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked req");
    property p_req_stay;
        timer_irq_req && !cpu_irq_mask && !s_axi_arvalid && !s_axi_awvalid
            && !$past(s_axi_awvalid) |=> timer_irq_req;
    endproperty
    a_req_stay: assert property (p_req_stay) else $error("req lost");

    c_unmap: cover property (s_axi_arvalid && s_axi_araddr == 8'h24);
    c_req: cover property ($rose(timer_irq_req));
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule : tfrc_timer_checker

bind tfrc_timer tfrc_timer_checker u_chk (.*);

`default_nettype wire

// ===== tb/tfrc_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tfrc_timer_tb
    import tfrc_pkg::*;
;
    logic        aclk, aresetn, cpu_irq_mask, wait_mode, halt_mode;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, timer_irq_req, irq, ext_tick_pin;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, e;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          mismatches, check_count;

    tfrc_timer uut (.*);
    tfrc_ext_src src (.aclk, .ext_tick_pin);

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        if (mismatches == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic waitfor(ref logic s);
        int n;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (s !== 1'b1 && n < 200);
        if (s !== 1'b1)
        begin
            mismatches++;
            test_done();
        end
    endtask : waitfor

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        waitfor(s_axi_arready);
        s_axi_arvalid <= 1'b0;
        waitfor(s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ad;
        logic dd;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        ad = 1'b0;
        dd = 1'b0;
        while (!(ad && dd))
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
            begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1)
            begin
                dd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        waitfor(s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        rd(a);
        chk($sformatf("rd %h", a), d, x);
    endtask : rc

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // reset count
    task automatic t_reset();
        rc(TFRC_CNT_HI_OFS, 32'hFF);
        rc(TFRC_CNT_LO_OFS, 32'hFC);
    endtask : t_reset

    task automatic t_buffer();
        wr(TFRC_CTRL2_OFS, 32'h7);
        halt_mode <= 1'b0;
        wr(TFRC_ALT_LO_OFS, 32'h0);
        src.pulse(1);
        rc(TFRC_CNT_HI_OFS, 32'hFF);
        src.pulse(2);
        rc(TFRC_ALT_HI_OFS, 32'hFF);
        rc(TFRC_CNT_LO_OFS, 32'hFD);
        rc(TFRC_CNT_LO_OFS, 32'hFF);
    endtask : t_buffer

    task automatic t_ovf();
        wr(TFRC_CTRL1_OFS, 32'h1);
        wr(TFRC_IRQ_MASK_OFS, 32'h1);
        cpu_irq_mask <= 1'b1;
        src.pulse(1);
        chk("req", timer_irq_req, 0);
        cpu_irq_mask <= 1'b0;
        @(posedge aclk);
        chk("req", timer_irq_req, 1);
        chk("irq", irq, 1);
        wr(TFRC_IRQ_MASK_OFS, 32'h0);
        chk("irq", irq, 0);
        wr(TFRC_IRQ_MASK_OFS, 32'h1);
        rc(TFRC_STATUS_OFS, 32'h1);
        rc(TFRC_ALT_LO_OFS, 32'h0);
        rc(TFRC_STATUS_OFS, 32'h1);
        rc(TFRC_CNT_LO_OFS, 32'h0);
        rc(TFRC_STATUS_OFS, 32'h0);
        chk("req", timer_irq_req, 0);
        rc(TFRC_IRQ_STAT_OFS, 32'h1);
        chk("irq", irq, 0);
    endtask : t_ovf

    task automatic t_load();
        wr(TFRC_CNT_LO_OFS, 32'h55);
        rc(TFRC_CNT_HI_OFS, 32'hFF);
        rc(TFRC_CNT_LO_OFS, 32'hFC);
        wr(TFRC_CTRL2_OFS, 32'h3);
        src.pulse(2);
        rc(TFRC_CNT_LO_OFS, 32'hFE);
    endtask : t_load

    task automatic t_div();
        logic [7:0] df;
        wait_mode <= 1'b1;
        for (int s = 0; s < 3; s++)
        begin
            wr(TFRC_CTRL2_OFS, 32'(s));
            rd(TFRC_CNT_LO_OFS);
            e = d;
            repeat (64) @(posedge aclk);
            rd(TFRC_CNT_LO_OFS);
            df = d[7:0] - e[7:0];
            e = 67 >> (s + 1);
            chk("div", 32'(df >= e[7:0] && df <= e[7:0] + 1), 1);
        end
    endtask : t_div

    task automatic t_halt();
        halt_mode <= 1'b1;
        rd(TFRC_CNT_LO_OFS);
        e = d;
        repeat (40) @(posedge aclk);
        rc(TFRC_CNT_LO_OFS, e);
        halt_mode <= 1'b0;
        repeat (40) @(posedge aclk);
        rd(TFRC_CNT_LO_OFS);
        chk("resume", 32'(d[7:0] - e[7:0] > 8'h2), 1);
    endtask : t_halt

    task automatic t_unmap();
        rc(8'h24, 32'h0);
        chk("rresp", r, TFRC_RESP_SLVERR);
        wr(8'h24, 32'h1);
        chk("bresp", r, TFRC_RESP_SLVERR);
    endtask : t_unmap

    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
        {s_axi_rready, cpu_irq_mask, wait_mode, aresetn} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_awprot, s_axi_arprot} = 6'h0;
        s_axi_wstrb = 4'hF;
        halt_mode = 1'b1;
        mismatches = 0;
        check_count = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_buffer();
        t_ovf();
        t_load();
        t_div();
        t_halt();
        t_unmap();
        aresetn <= 1'b0;
        halt_mode <= 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        test_done();
    end
endmodule : tfrc_timer_tb

`default_nettype wire
